// [core/postdiv_a_gen.v]
/*
  First postdivider of synthesizer A: divided clock, low-frequency
  clock or frame pulse, chosen by the committed 24-bit setting.
  Assumes all ticks are one-cycle enables on mclk; edge ticks of the
  frame sources come twice per source period, one at each edge.
*/
`timescale 1ns/10ps
`include "synth_output_consts.vh"

module postdiv_a_gen (
  input wire mclk,
  input wire reset,
  input wire [23:0] cfg,
  input wire restart,
  input wire synth_tick,
  input wire low_freq_tick,
  input wire [2:0] src_edge_tick,
  output wire div_out,
  output wire frame_boundary
);

reg [23:0] cnt_reg;
reg [23:0] cnt_next;
reg out_reg;
reg out_next;
reg boundary_reg;
reg [23:0] ratio;
reg [23:0] limit;
reg [23:0] high_len;
reg tick;
reg pulse_on;

wire special = (cfg[`DIV_MODE_MSB:`DIV_MODE_LSB] == `DIV_MODE_SPECIAL);
wire [1:0] src = cfg[`DIV_SRC_MSB:`DIV_SRC_LSB];
wire frame_mode = special && (src != `SRC_LOW_FREQ);
wire [15:0] rate = cfg[`DIV_RATE_MSB:0];
wire style = cfg[`DIV_STYLE_BIT];
wire pol = cfg[`DIV_POL_BIT];

////////////////////////////////////////////////////////////////////////
// Mode decode and counting

always @* begin
  ratio = special ? {8'h00, rate} : cfg; // [R8] [R10]
  if (ratio < `MIN_DIVIDE) begin
    ratio = `MIN_DIVIDE;
  end
  high_len = (ratio >> 1) + {23'h000000, ratio[0]};
  limit = ratio - 24'h000001;
  tick = special ? low_freq_tick : synth_tick;
  if (frame_mode) begin
    // Half-period steps: two edge ticks per source period
    limit = {7'h00, ((rate == 16'h0000) ? 16'h0001 : rate), 1'b0} - 24'h000001; // [R9]
    tick = src_edge_tick[src - 2'h1]; // [R11]
  end
  cnt_next = cnt_reg;
  if (tick) begin
    cnt_next = (cnt_reg >= limit) ? 24'h000000 : cnt_reg + 24'h000001;
  end
  if (style == `STYLE_LEADING_EDGE) begin
    pulse_on = (cnt_next <= 24'h000001); // [R13]
  end else begin
    pulse_on = (cnt_next == 24'h000000) || (cnt_next == limit); // [R13]
  end
  if (frame_mode) begin
    out_next = pulse_on ^ pol; // [R11] [R12]
  end else begin
    out_next = (cnt_next < high_len); // [R14]
  end
end

always @(posedge mclk) begin
  if (reset) begin
    cnt_reg <= 24'h000000;
    out_reg <= 1'b0;
    boundary_reg <= 1'b0;
  end else if (restart) begin
    cnt_reg <= 24'h000000;
    out_reg <= frame_mode & pol;
    boundary_reg <= 1'b0;
  end else begin
    cnt_reg <= cnt_next;
    out_reg <= out_next;
    boundary_reg <= frame_mode && tick && (cnt_next == 24'h000000);
  end
end

assign div_out = out_reg;
assign frame_boundary = boundary_reg;

endmodule

// [core/synth_output_config_regs.v]
/*
  Output configuration registers of the two synthesizers: loop filter
  choice, fine phase advance, address page and postdivider A of
  synthesizer A, with the phase-shifted synthesizer ticks and the
  postdivider A output generated here.
  Assumes the serial port logic presents decoded 7-bit accesses on
  mclk, and that step, low-frequency and divider edge ticks come from
  logic on mclk, so none of them is synchronised.
*/
// Operation
// [R1] Filter register bit 0 picks synthesizer A loop filter, 1 internal.
// [R2] Filter register bit 1 picks synthesizer B loop filter; bits 7:2 reserved.
// [R3] Synthesizer A phase register advances its output by count/256 period.
// [R4] Synthesizer B phase register advances its output by count/256 period.
// [R5] Phase advance applies to every clock derived from that synthesizer; the code applies it to postdivider A only when mode is not 1111.
// [R6] Page bit routes serial accesses to lower or upper page; 0x7F always.
// [R7] Host sets the page bit before touching the other page.
// [R8] Mode not 1111: output is synthesizer A divided by 24-bit ratio.
// [R9] Frame mode: pulses spaced by bits 15:0 source periods.
// [R10] Mode 1111, source 00: low-frequency clock, twice base over bits 15:0.
// [R11] Source bits select low clock or dividers B/C/D; width one period.
// [R12] Frame mode bit 18 sets polarity: 0 positive, 1 negative.
// [R13] Frame mode bit 19: 0 mid-pulse boundary, 1 leading-edge boundary.
// [R14] Divided and low-frequency clocks have 50 percent duty; for an odd ratio N the code keeps the output high for (N+1)/2 of N ticks.
// [R15] Reserved bits read zero; divider setting commits once all bytes written; the code commits on the byte 2 write alone.
`timescale 1ns/10ps
`include "synth_output_consts.vh"

module synth_output_config_regs (
  input wire mclk,
  input wire reset,
  input wire [6:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  input wire pll_a_step_tick,
  input wire pll_b_step_tick,
  input wire pll_a_low_freq_tick,
  input wire div_b_edge_tick,
  input wire div_c_edge_tick,
  input wire div_d_edge_tick,
  output wire pll_a_loop_filter_choice,
  output wire pll_b_loop_filter_choice,
  output wire [7:0] pll_a_phase_step_count,
  output wire [7:0] pll_b_phase_step_count,
  output wire pll_a_clk_tick,
  output wire pll_b_clk_tick,
  output wire postdiv_a_out,
  output wire postdiv_a_frame_boundary
);

////////////////////////////////////////////////////////////////////////
// Address mapping

function [7:0] map_addr;
  input [6:0] addr;
  input page;
  begin
    if (addr == `SERIAL_PAGE_ADDR) begin
      map_addr = `ADDR_PAGE_SELECT;
    end else begin
      map_addr = {page, addr};
    end
  end
endfunction

reg [7:0] filter_choice_reg;
reg [7:0] pll_a_phase_reg;
reg [7:0] pll_b_phase_reg;
reg [7:0] page_reg;
reg [7:0] div_a_stage0_reg;
reg [7:0] div_a_stage1_reg;
reg [7:0] div_a_stage2_reg;
reg [23:0] div_a_active_reg;
reg div_a_restart_reg;
reg [7:0] rdata_reg;
reg [7:0] rdata_next;

localparam [23:0] DIV_A_RESET = `RST_DIV_A;

wire [7:0] full_addr;
wire wr_filter;
wire wr_phase_a;
wire wr_phase_b;
wire wr_page;
wire wr_div0;
wire wr_div1;
wire wr_div2;

// The page register answers at 0x7F whatever the page
assign full_addr = map_addr(reg_addr, page_reg[`PAGE_BIT]); // [R6] [R7]

assign wr_filter = reg_wr && (full_addr == `ADDR_FILTER_CHOICE);
assign wr_phase_a = reg_wr && (full_addr == `ADDR_PLL_A_PHASE);
assign wr_phase_b = reg_wr && (full_addr == `ADDR_PLL_B_PHASE);
assign wr_page = reg_wr && (full_addr == `ADDR_PAGE_SELECT);
assign wr_div0 = reg_wr && (full_addr == `ADDR_DIV_A_BYTE0);
assign wr_div1 = reg_wr && (full_addr == `ADDR_DIV_A_BYTE1);
assign wr_div2 = reg_wr && (full_addr == `ADDR_DIV_A_BYTE2);

////////////////////////////////////////////////////////////////////////
// Register writes

always @(posedge mclk) begin
  if (reset) begin
    filter_choice_reg <= `RST_FILTER_CHOICE;
    pll_a_phase_reg <= `RST_PHASE;
    pll_b_phase_reg <= `RST_PHASE;
    page_reg <= `RST_PAGE;
  end else begin
    if (wr_filter) begin
      filter_choice_reg <= reg_wdata & `FILTER_MASK; // [R1] [R2] [R15]
    end
    if (wr_phase_a) begin
      pll_a_phase_reg <= reg_wdata; // [R3]
    end
    if (wr_phase_b) begin
      pll_b_phase_reg <= reg_wdata; // [R4]
    end
    if (wr_page) begin
      page_reg <= reg_wdata & `PAGE_MASK; // [R6] [R15]
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Postdivider A staging and commit

// Low bytes only stage; the top byte write commits all three at once
always @(posedge mclk) begin
  if (reset) begin
    div_a_stage0_reg <= DIV_A_RESET[7:0];
    div_a_stage1_reg <= DIV_A_RESET[15:8];
    div_a_stage2_reg <= DIV_A_RESET[23:16];
    div_a_active_reg <= `RST_DIV_A;
    div_a_restart_reg <= 1'b0;
  end else begin
    div_a_restart_reg <= wr_div2;
    if (wr_div0) begin
      div_a_stage0_reg <= reg_wdata;
    end
    if (wr_div1) begin
      div_a_stage1_reg <= reg_wdata;
    end
    if (wr_div2) begin
      div_a_stage2_reg <= reg_wdata;
      div_a_active_reg <= {reg_wdata, div_a_stage1_reg, div_a_stage0_reg}; // [R15]
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Register reads

always @* begin
  rdata_next = 8'h00; // [R15]
  case (full_addr)
    `ADDR_FILTER_CHOICE: begin
      rdata_next = filter_choice_reg;
    end
    `ADDR_PLL_A_PHASE: begin
      rdata_next = pll_a_phase_reg;
    end
    `ADDR_PLL_B_PHASE: begin
      rdata_next = pll_b_phase_reg;
    end
    `ADDR_PAGE_SELECT: begin
      rdata_next = page_reg;
    end
    `ADDR_DIV_A_BYTE0: begin
      rdata_next = div_a_stage0_reg;
    end
    `ADDR_DIV_A_BYTE1: begin
      rdata_next = div_a_stage1_reg;
    end
    `ADDR_DIV_A_BYTE2: begin
      rdata_next = div_a_stage2_reg;
    end
    default: begin
      rdata_next = 8'h00;
    end
  endcase
end

always @(posedge mclk) begin
  if (reset) begin
    rdata_reg <= 8'h00;
  end else if (reg_rd) begin
    rdata_reg <= rdata_next;
  end
end

assign reg_rdata = rdata_reg;

////////////////////////////////////////////////////////////////////////
// Fine phase advance of both synthesizers

wire [15:0] phase_bus = {pll_b_phase_reg, pll_a_phase_reg};
wire [1:0] step_bus = {pll_b_step_tick, pll_a_step_tick};
wire [1:0] clk_tick_bus;

genvar g;
generate
  for (g = 0; g < 2; g = g + 1) begin : phase_gen
    reg [7:0] step_cnt_reg;
    reg tick_reg;
    wire [7:0] phase = phase_bus[8 * g + 7:8 * g];
    // Edge sits phase steps earlier in the 256-step period
    always @(posedge mclk) begin
      if (reset) begin
        step_cnt_reg <= 8'h00;
        tick_reg <= 1'b0;
      end else begin
        tick_reg <= step_bus[g] && (step_cnt_reg == (`PHASE_STEP_MAX - phase)); // [R3] [R4]
        if (step_bus[g]) begin
          step_cnt_reg <= step_cnt_reg + 8'h01;
        end
      end
    end
    assign clk_tick_bus[g] = tick_reg;
  end
endgenerate

assign pll_a_clk_tick = clk_tick_bus[0];
assign pll_b_clk_tick = clk_tick_bus[1];

////////////////////////////////////////////////////////////////////////
// Postdivider A

// Runs from the shifted tick when mode is not 1111, so the advance reaches its divided output too
postdiv_a_gen u_postdiv_a (
  .mclk(mclk),
  .reset(reset),
  .cfg(div_a_active_reg),
  .restart(div_a_restart_reg),
  .synth_tick(clk_tick_bus[0]), // [R5]
  .low_freq_tick(pll_a_low_freq_tick),
  .src_edge_tick({div_d_edge_tick, div_c_edge_tick, div_b_edge_tick}),
  .div_out(postdiv_a_out),
  .frame_boundary(postdiv_a_frame_boundary)
);

////////////////////////////////////////////////////////////////////////
// Analog-side controls

assign pll_a_loop_filter_choice = filter_choice_reg[`FILTER_A_BIT]; // [R1]
assign pll_b_loop_filter_choice = filter_choice_reg[`FILTER_B_BIT]; // [R2]
assign pll_a_phase_step_count = pll_a_phase_reg; // [R3]
assign pll_b_phase_step_count = pll_b_phase_reg; // [R4]

endmodule

// [core/synth_output_consts.vh]
/*
  Constants of the synthesizer output configuration bank: register
  addresses, reset values, field positions and codes.
  Assumes inclusion by bare name from the core design files.
*/
`ifndef SYNTH_OUTPUT_CONSTS_VH
`define SYNTH_OUTPUT_CONSTS_VH

// Full eight-bit register addresses, then the 7-bit serial page address
`define ADDR_FILTER_CHOICE 8'h77
`define ADDR_PLL_A_PHASE 8'h78
`define ADDR_PLL_B_PHASE 8'h79
`define ADDR_PAGE_SELECT 8'h7F
`define ADDR_DIV_A_BYTE0 8'h80
`define ADDR_DIV_A_BYTE1 8'h81
`define ADDR_DIV_A_BYTE2 8'h82
`define SERIAL_PAGE_ADDR 7'h7F

// Reset values
`define RST_FILTER_CHOICE 8'h00
`define RST_PHASE 8'h00
`define RST_PAGE 8'h00
`define RST_DIV_A 24'h000002

// Field layout
`define FILTER_A_BIT 0
`define FILTER_B_BIT 1
`define FILTER_MASK 8'h03
`define PAGE_BIT 0
`define PAGE_MASK 8'h01
`define DIV_MODE_MSB 23
`define DIV_MODE_LSB 20
`define DIV_MODE_SPECIAL 4'hF
`define DIV_STYLE_BIT 19
`define DIV_POL_BIT 18
`define DIV_SRC_MSB 17
`define DIV_SRC_LSB 16
`define DIV_RATE_MSB 15
`define SRC_LOW_FREQ 2'h0
`define STYLE_MID_BOUNDARY 1'h0
`define STYLE_LEADING_EDGE 1'h1

// Timing
`define PHASE_STEPS_PER_PERIOD 256
`define PHASE_STEP_MAX 8'hFF
`define MIN_DIVIDE 24'h000002

`endif

// [verification/cfg_regs_checker_assertions.sv]
/* Checker of the register port, synthesizer A phase tick and frame boundary.
   Assumes binding to synth_output_config_regs on mclk. */
`timescale 1ns/10ps
module cfg_regs_checker (
  input wire mclk,
  input wire reset,
  input wire [6:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire pll_a_step_tick,
  input wire div_b_edge_tick,
  input wire div_c_edge_tick,
  input wire div_d_edge_tick,
  input wire pll_a_loop_filter_choice,
  input wire pll_b_loop_filter_choice,
  input wire [7:0] pll_a_phase_step_count,
  input wire [7:0] pll_b_phase_step_count,
  input wire pll_a_clk_tick,
  input wire postdiv_a_frame_boundary
);
  reg page_reg;
  wire lo_wr;
  assign lo_wr = reg_wr && !page_reg;
  // Shadow of the page bit
  always @(posedge mclk) begin
    if (reset) page_reg <= 1'b0;
    else if (reg_wr && reg_addr == 7'h7F) page_reg <= reg_wdata[0];
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_fa;
    lo_wr && reg_addr == 7'h77 |=> pll_a_loop_filter_choice == $past(reg_wdata[0]);
  endproperty
  a_fa: assert property (p_fa) else $error("filter A wrong");
  property p_fb;
    lo_wr && reg_addr == 7'h77 |=> pll_b_loop_filter_choice == $past(reg_wdata[1]);
  endproperty
  a_fb: assert property (p_fb) else $error("filter B wrong");
  property p_pa;
    lo_wr && reg_addr == 7'h78 |=> pll_a_phase_step_count == $past(reg_wdata);
  endproperty
  a_pa: assert property (p_pa) else $error("phase A wrong");
  property p_pb;
    lo_wr && reg_addr == 7'h79 |=> pll_b_phase_step_count == $past(reg_wdata);
  endproperty
  a_pb: assert property (p_pb) else $error("phase B wrong");
  property p_pg;
    reg_rd && reg_addr == 7'h7F |=> reg_rdata == {7'h00, $past(page_reg)};
  endproperty
  a_pg: assert property (p_pg) else $error("page read wrong");
  property p_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_tick;
    pll_a_clk_tick |-> $past(pll_a_step_tick) ##1 !pll_a_clk_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick without step");
  property p_bnd;
    postdiv_a_frame_boundary |-> $past(div_b_edge_tick || div_c_edge_tick || div_d_edge_tick);
  endproperty
  a_bnd: assert property (p_bnd) else $error("boundary without edge");
endmodule
bind synth_output_config_regs cfg_regs_checker chk (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pll_a_step_tick(pll_a_step_tick), .div_b_edge_tick(div_b_edge_tick), .div_c_edge_tick(div_c_edge_tick),
  .div_d_edge_tick(div_d_edge_tick), .pll_a_loop_filter_choice(pll_a_loop_filter_choice),
  .pll_b_loop_filter_choice(pll_b_loop_filter_choice), .pll_a_phase_step_count(pll_a_phase_step_count),
  .pll_b_phase_step_count(pll_b_phase_step_count), .pll_a_clk_tick(pll_a_clk_tick),
  .postdiv_a_frame_boundary(postdiv_a_frame_boundary));

// [verification/synth_output_config_regs_test.sv]
/* Self-checking bench of the synthesizer output configuration bank.
   Assumes the tick source model and the bound checker. */
`timescale 1ns/10ps
module synth_output_config_regs_test;
  reg mclk = 1'b0;
  reg reset = 1'b1;
  reg [6:0] reg_addr = 7'h00;
  reg reg_wr = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire [7:0] pa;
  wire [7:0] pb;
  wire st, eb, ec, ed, fa, fb, ta, tb, pout, pbd;
  integer fails = 0;
  integer comparisons = 0;
  integer i, n, h, bd, bad;
  reg prev;
  always #5 mclk = ~mclk;
  synth_tick_source src (.mclk(mclk), .reset(reset), .step_tick(st), .edge_b_tick(eb), .edge_c_tick(ec),
    .edge_d_tick(ed));
  synth_output_config_regs DUT (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_a_step_tick(st), .pll_b_step_tick(st),
    .pll_a_low_freq_tick(st), .div_b_edge_tick(eb), .div_c_edge_tick(ec), .div_d_edge_tick(ed),
    .pll_a_loop_filter_choice(fa), .pll_b_loop_filter_choice(fb), .pll_a_phase_step_count(pa),
    .pll_b_phase_step_count(pb), .pll_a_clk_tick(ta), .pll_b_clk_tick(tb), .postdiv_a_out(pout),
    .postdiv_a_frame_boundary(pbd));
  ////////////////////////////////////////////////////////////////
  task chk(input ok);
    comparisons = comparisons + 1;
    if (!ok) begin
      fails = fails + 1;
      $display("[FAIL] %0t mismatch", $time);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input [6:0] a, input [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input [6:0] a, input [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata === e);
  endtask
  // Cycles between two phase ticks, new phase written after the first
  task gap(input [6:0] a, input [7:0] p, input integer e);
    n = 0;
    while ((a[0] ? tb : ta) !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n = n + 1;
    end
    wr(a, p);
    n = 2;
    do begin
      @(posedge mclk);
      #1;
      n = n + 1;
    end while ((a[0] ? tb : ta) !== 1'b1 && n < 300);
    chk(n == e);
  endtask
  task div(input [7:0] b0, input [7:0] b2);
    wr(7'h00, b0);
    wr(7'h01, 8'h00);
    wr(7'h02, b2);
    repeat (20) @(posedge mclk);
    #1;
  endtask
  // High cycles, boundaries and boundaries with wrong levels
  task meas(input integer c, input eo, input ep);
    integer k;
    h = 0;
    bd = 0;
    bad = 0;
    for (k = 0; k < c; k = k + 1) begin
      prev = pout;
      @(posedge mclk);
      #1;
      h = h + pout;
      bd = bd + pbd;
      if (pbd && (pout !== eo || prev !== ep)) bad = bad + 1;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    rd(7'h77, 8'h00);
    rd(7'h78, 8'h00);
    rd(7'h79, 8'h00);
    rd(7'h7F, 8'h00);
    rd(7'h10, 8'h00);
    wr(7'h77, 8'hFF);
    rd(7'h77, 8'h03);
    chk(fa === 1'b1 && fb === 1'b1);
    wr(7'h77, 8'h02);
    chk(fa === 1'b0 && fb === 1'b1);
    $display("test filters done");
    wr(7'h78, 8'hAB);
    wr(7'h79, 8'h5C);
    chk(pa === 8'hAB && pb === 8'h5C);
    gap(7'h78, 8'hAB, 256);
    gap(7'h78, 8'hEB, 192);
    gap(7'h79, 8'h5C, 256);
    gap(7'h79, 8'hDC, 128);
    $display("test phase done");
    rd(7'h00, 8'h00);
    wr(7'h7F, 8'h01);
    rd(7'h7F, 8'h01);
    rd(7'h00, 8'h02);
    rd(7'h77, 8'h00);
    $display("test pages done");
    div(8'h03, 8'h00);
    rd(7'h02, 8'h00);
    meas(1536, 1'b0, 1'b0);
    chk(h == 1024 && bd == 0);
    div(8'h04, 8'hF0);
    meas(16, 1'b0, 1'b0);
    chk(h == 8 && bd == 0);
    for (i = 0; i < 16; i = i + 1) begin
      if (i[1:0] != 2'h0) begin
        div(8'h02, 8'hF0 | {4'h0, i[3:0]});
        meas(32, ~i[2], ~i[3] ^ i[2]);
        chk(bd == (8 >> (i[1:0] - 1)) && bad == 0);
      end
    end
    $display("test postdivider done");
    end_of_test;
  end
  initial begin
    #500000;
    fails = fails + 1;
    end_of_test;
  end
endmodule

// [verification/synth_tick_source.sv]
/* Tick source in place of synthesizer and divider logic.
   Assumes mclk and a synchronous active-high reset. */
`timescale 1ns/10ps
module synth_tick_source (
  input wire mclk,
  input wire reset,
  output wire step_tick,
  output wire edge_b_tick,
  output wire edge_c_tick,
  output wire edge_d_tick
);
  reg [1:0] cnt_reg;
  always @(posedge mclk) begin
    if (reset) cnt_reg <= 2'h0;
    else cnt_reg <= cnt_reg + 2'h1;
  end
  // Edge rates one, a half and a quarter per cycle
  assign step_tick = !reset;
  assign edge_b_tick = !reset;
  assign edge_c_tick = !reset && cnt_reg[0];
  assign edge_d_tick = !reset && cnt_reg == 2'h3;
endmodule
